// ==== design/rscl_strap_latch.sv ====
// Reset strap capture, configuration decode and peripheral select register
//
// Behaviour
// [RULE1] Sample endian, four address straps, host enable and width straps during reset.
// [RULE2] Latched endian 0 gives big-endian, 1 gives little-endian (pull-up default).
// [RULE3] Boot mode 00 none, 01 host port, 10 reserved, 11 8-bit ROM.
// [RULE4] Memory clock 00 dedicated pin, 01 CPU/4, 10 CPU/6, 11 reserved.
// [RULE5] Host enable strap 0 enables host port; 1 enables audio port and upper GPIO.
// [RULE6] Width 0 gives 16-bit host port, upper lines released; 1 gives 32-bit.
// [RULE7] PLL source 0 takes crystal pads, 1 takes square-wave clock pin.
// [RULE8] Outside party drives oscillator disable equal to the PLL source select.
// [RULE9] Source select and oscillator disable pins change only while reset is low.
// [RULE10] After reset the device drives shared pins; outside driver must release them.
// [RULE11] Software changes further selections through the peripheral select register.
// [RULE12] Latched strap values stay unchanged until reset is asserted again.
`timescale 1ns/1ps
`include "rscl_cfg.svh"
module rscl_strap_latch (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Strap pins
  input wire logic byte_order_strap_i,
  input wire logic [3:0] ext_addr_strap_bus_i,
  input wire logic host_port_enable_strap_i,
  input wire logic host_width_strap_i,
  input wire logic pll_source_select_i,
  input wire logic oscillator_disable_i,
  // Sources driven onto shared pins after reset, and the memory clock pin input
  input wire logic timer0_output_i,
  input wire logic timer1_output_i,
  input wire logic mem_clock_input_i,
  // Register port
  input wire logic reg_req_i,
  input wire logic reg_we_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic reg_ack_o,
  output logic [31:0] reg_rdata_o,
  // Decoded configuration
  output logic byte_order_mode_o,
  output rscl_pkg::rscl_boot_type boot_mode_o,
  output logic boot_reserved_o,
  output rscl_pkg::rscl_mclk_type mem_clock_select_o,
  output logic mem_clk_en_o,
  output logic mem_clk_reserved_o,
  output logic host_port_en_o,
  output logic audio2_en_o,
  output logic gpio_hi_en_o,
  output logic host_port_width_o,
  output logic host_upper_en_o,
  output logic pll_source_o,
  output logic osc_mismatch_o,
  output logic clk_pin_changed_o,
  output logic [31:0] peripheral_select_o,
  // Shared pin drive
  output logic timer0_output_o,
  output logic timer0_output_oe_o,
  output logic timer1_output_o,
  output logic timer1_output_oe_o,
  output logic ext_addr_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture

  rscl_pkg::rscl_strap_type strap_now;
  rscl_pkg::rscl_strap_type latch_q;
  logic pll_src_q;

  assign strap_now.byte_order = byte_order_strap_i;
  assign strap_now.boot = rscl_pkg::rscl_boot_type'(ext_addr_strap_bus_i[3:2]);
  assign strap_now.mclk = rscl_pkg::rscl_mclk_type'(ext_addr_strap_bus_i[1:0]);
  assign strap_now.host_dis = host_port_enable_strap_i;
  assign strap_now.width = host_width_strap_i;

  // Sync reset lets the flops follow the pins on every clock edge in reset; last one wins
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      latch_q <= strap_now; // [RULE1]
      pll_src_q <= pll_source_select_i; // [RULE7]
    end
  end
  // Without reset the latch has no enable, so it holds [RULE12]

  ////////////////////////////////////////////////////////////////////////////
  // Memory clock enables

  logic div4_pulse;
  logic div6_pulse;

  rscl_clk_div #(.DIV(`RSCL_DIV_CPU4)) u_div4 (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .pulse_o(div4_pulse)
  );

  rscl_clk_div #(.DIV(`RSCL_DIV_CPU6)) u_div6 (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .pulse_o(div6_pulse)
  );

  // Reserved code gives no memory clock rather than guessing a rate
  wire mclk_en_d = (latch_q.mclk == rscl_pkg::RSCL_MCLK_PIN) ? mem_clock_input_i :
                   (latch_q.mclk == rscl_pkg::RSCL_MCLK_DIV4) ? div4_pulse :
                   (latch_q.mclk == rscl_pkg::RSCL_MCLK_DIV6) ? div6_pulse : 1'b0; // [RULE4]

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  wire host_en_d = ~latch_q.host_dis; // [RULE5]
  wire upper_en_d = host_en_d & latch_q.width; // [RULE6]
  wire boot_resv_d = (latch_q.boot == rscl_pkg::RSCL_BOOT_RESV); // [RULE3]
  wire mclk_resv_d = (latch_q.mclk == rscl_pkg::RSCL_MCLK_RESV); // [RULE4]
  // Pin levels are watched, not trusted: the PLL keeps the latched source
  wire mismatch_d = (pll_source_select_i != oscillator_disable_i); // [RULE8]
  wire changed_set = (pll_source_select_i != pll_src_q); // [RULE9]

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      byte_order_mode_o <= `RSCL_BYTE_ORDER_DEFAULT;
      boot_mode_o <= rscl_pkg::RSCL_BOOT_NONE;
      boot_reserved_o <= 1'b0;
      mem_clock_select_o <= rscl_pkg::RSCL_MCLK_PIN;
      mem_clk_en_o <= 1'b0;
      mem_clk_reserved_o <= 1'b0;
      host_port_en_o <= ~`RSCL_HOST_DIS_DEFAULT;
      audio2_en_o <= `RSCL_HOST_DIS_DEFAULT;
      gpio_hi_en_o <= `RSCL_HOST_DIS_DEFAULT;
      host_port_width_o <= `RSCL_WIDTH_DEFAULT;
      host_upper_en_o <= 1'b0;
      pll_source_o <= `RSCL_PLL_SRC_DEFAULT;
      osc_mismatch_o <= 1'b0;
      clk_pin_changed_o <= 1'b0;
    end
    else
    begin
      byte_order_mode_o <= latch_q.byte_order; // [RULE2]
      boot_mode_o <= latch_q.boot; // [RULE3]
      boot_reserved_o <= boot_resv_d;
      mem_clock_select_o <= latch_q.mclk; // [RULE4]
      mem_clk_en_o <= mclk_en_d;
      mem_clk_reserved_o <= mclk_resv_d;
      host_port_en_o <= host_en_d; // [RULE5]
      audio2_en_o <= latch_q.host_dis; // [RULE5]
      gpio_hi_en_o <= latch_q.host_dis; // [RULE5]
      host_port_width_o <= latch_q.width; // [RULE6]
      host_upper_en_o <= upper_en_d; // [RULE6]
      pll_source_o <= pll_src_q; // [RULE7]
      osc_mismatch_o <= mismatch_d; // [RULE8]
      clk_pin_changed_o <= clk_pin_changed_o | changed_set; // [RULE9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared pin drive, released during reset so the straps can be read

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      timer0_output_o <= 1'b0;
      timer1_output_o <= 1'b0;
      timer0_output_oe_o <= 1'b0;
      timer1_output_oe_o <= 1'b0;
      ext_addr_oe_o <= 1'b0;
    end
    else
    begin
      timer0_output_o <= timer0_output_i;
      timer1_output_o <= timer1_output_i;
      timer0_output_oe_o <= 1'b1; // [RULE10]
      timer1_output_oe_o <= 1'b1; // [RULE10]
      ext_addr_oe_o <= 1'b1; // [RULE10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  wire hit_psel = (reg_addr_i == `RSCL_PERIPH_SEL_ADDR);
  wire hit_stat = (reg_addr_i == `RSCL_STATUS_ADDR);
  wire psel_wr = reg_req_i & reg_we_i & hit_psel;
  wire rd = reg_req_i & ~reg_we_i;

  logic [31:0] status_word;
  always_comb
  begin
    status_word = '0;
    status_word[`RSCL_STAT_STRAP_MSB:`RSCL_STAT_STRAP_LSB] = latch_q;
    status_word[`RSCL_STAT_MISMATCH_BIT] = osc_mismatch_o;
    status_word[`RSCL_STAT_CHANGED_BIT] = clk_pin_changed_o;
  end

  // Unmapped reads return zero; unmapped writes are dropped but still acked
  wire [31:0] rdata_d = hit_psel ? peripheral_select_o :
                        hit_stat ? status_word : 32'h00000000;

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      peripheral_select_o <= `RSCL_PERIPH_SEL_RESET;
      reg_ack_o <= 1'b0;
      reg_rdata_o <= 32'h00000000;
    end
    else
    begin
      if (psel_wr)
        peripheral_select_o <= reg_wdata_i; // [RULE11]
      reg_ack_o <= reg_req_i;
      if (rd)
        reg_rdata_o <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_reset_leaves;
    $rose(resetn_i);
  endsequence

  sequence s_pads_float_then_drive;
    !timer0_output_oe_o && !ext_addr_oe_o ##1 timer0_output_oe_o && timer1_output_oe_o;
  endsequence

  chk_strap_sample: assert property ( // [RULE1]
    s_reset_leaves |-> latch_q == $past(strap_now))
    else $error("Strap latch does not hold last value seen in reset");

  chk_latch_hold: assert property ( // [RULE12]
    $past(resetn_i) |-> $stable(latch_q) && $stable(pll_src_q))
    else $error("Strap latch changed outside reset");

  chk_endian_map: assert property ( // [RULE2]
    $past(resetn_i) |=> byte_order_mode_o == $past(latch_q.byte_order))
    else $error("Byte order mode does not follow latched strap");

  chk_boot_decode: assert property ( // [RULE3]
    $past(resetn_i) && latch_q.boot == rscl_pkg::RSCL_BOOT_RESV |=> boot_reserved_o)
    else $error("Reserved boot code not flagged");

  chk_mclk_reserved: assert property ( // [RULE4]
    $past(resetn_i) && latch_q.mclk == rscl_pkg::RSCL_MCLK_RESV |=> !mem_clk_en_o[*3])
    else $error("Memory clock enable runs on reserved code");

  chk_host_mux: assert property ( // [RULE5]
    $past(resetn_i, 2) |-> host_port_en_o != gpio_hi_en_o && audio2_en_o == gpio_hi_en_o)
    else $error("Host port and audio/GPIO both or neither enabled");

  chk_upper_lines: assert property ( // [RULE6]
    host_upper_en_o |-> host_port_width_o && host_port_en_o)
    else $error("Upper host lines driven in 16-bit or disabled mode");

  chk_pll_source: assert property ( // [RULE7]
    $past(resetn_i) |-> pll_source_o == pll_src_q)
    else $error("PLL source differs from latched select");

  chk_osc_match: assert property ( // [RULE8]
    pll_source_select_i != oscillator_disable_i |=> osc_mismatch_o)
    else $error("Oscillator mismatch not flagged");

  chk_pad_release: assert property ( // [RULE10]
    s_reset_leaves |-> s_pads_float_then_drive)
    else $error("Shared pins not taken one edge after reset release");

  chk_psel_write: assert property ( // [RULE11]
    psel_wr |=> reg_ack_o && peripheral_select_o == $past(reg_wdata_i))
    else $error("Peripheral select write lost");

endmodule : rscl_strap_latch

// ==== design/rscl_cfg.svh ====
// Addresses, field positions, reset values and divider counts for the strap latch
`ifndef RSCL_CFG_SVH
`define RSCL_CFG_SVH

`define RSCL_PERIPH_SEL_ADDR 32'h01b3f000
`define RSCL_STATUS_ADDR 32'h01b3f004
`define RSCL_PERIPH_SEL_RESET 32'h00000000

`define RSCL_STAT_STRAP_LSB 0
`define RSCL_STAT_STRAP_MSB 6
`define RSCL_STAT_MISMATCH_BIT 7
`define RSCL_STAT_CHANGED_BIT 8

`define RSCL_DIV_CPU4 4
`define RSCL_DIV_CPU6 6

`define RSCL_BYTE_ORDER_DEFAULT 1'b1
`define RSCL_PLL_SRC_DEFAULT 1'b1
`define RSCL_HOST_DIS_DEFAULT 1'b0
`define RSCL_WIDTH_DEFAULT 1'b1

`endif

// ==== design/rscl_pkg.sv ====
// Types shared by the strap latch
package rscl_pkg;

  typedef enum logic [1:0] {
    RSCL_BOOT_NONE = 2'h0,
    RSCL_BOOT_HOST = 2'h1,
    RSCL_BOOT_RESV = 2'h2,
    RSCL_BOOT_ROM8 = 2'h3
  } rscl_boot_type;

  typedef enum logic [1:0] {
    RSCL_MCLK_PIN = 2'h0,
    RSCL_MCLK_DIV4 = 2'h1,
    RSCL_MCLK_DIV6 = 2'h2,
    RSCL_MCLK_RESV = 2'h3
  } rscl_mclk_type;

  // Straps as captured at reset, 7 bits
  typedef struct packed {
    logic byte_order;
    rscl_boot_type boot;
    rscl_mclk_type mclk;
    logic host_dis;
    logic width;
  } rscl_strap_type;

endpackage : rscl_pkg

// ==== design/rscl_clk_div.sv ====
// Divider that emits a one-cycle enable every DIV system clocks
`timescale 1ns/1ps
module rscl_clk_div #(
  parameter int DIV = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Enable pulse
  output logic pulse_o
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;
  wire at_last = (cnt_q == LAST);

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      cnt_q <= '0;
      pulse_o <= 1'b0;
    end
    else
    begin
      cnt_q <= at_last ? '0 : cnt_q + CW'(1);
      pulse_o <= at_last;
    end
  end

endmodule : rscl_clk_div

// ==== verif/rscl_strap_drv.sv ====
// Pull resistors and configuration control device on the strap pins
`timescale 1ns/1ps
module rscl_strap_drv (
  // Control device
  input wire logic resetn_i,
  input wire logic ctl_drive_i,
  input wire rscl_pkg::rscl_strap_type ctl_straps_i,
  input wire logic ctl_pll_i,
  input wire logic bad_osc_i,
  input wire logic flip_pll_i,
  // Device pad drive
  input wire logic timer0_output_i,
  input wire logic timer0_output_oe_i,
  input wire logic timer1_output_i,
  input wire logic timer1_output_oe_i,
  input wire logic ext_addr_oe_i,
  // Pin levels
  output logic byte_order_strap_o,
  output logic [3:0] ext_addr_strap_bus_o,
  output logic host_port_enable_strap_o,
  output logic host_width_strap_o,
  output logic pll_source_select_o,
  output logic oscillator_disable_o
);
  logic drive;
  logic pll_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Control device lets go once reset is removed, pulls take over
  assign drive = ctl_drive_i & ~resetn_i;
  assign byte_order_strap_o = timer1_output_oe_i ? timer1_output_i :
    (drive ? ctl_straps_i.byte_order : 1'h1);
  assign host_port_enable_strap_o = timer0_output_oe_i ? timer0_output_i :
    (drive ? ctl_straps_i.host_dis : 1'h0);
  assign host_width_strap_o = drive ? ctl_straps_i.width : 1'h1;
  // Device address drive has no value port here, so show a pattern
  assign ext_addr_strap_bus_o = ext_addr_oe_i ? 4'ha :
    (drive ? {ctl_straps_i.boot, ctl_straps_i.mclk} : 4'h0);
  // Clock source pins move only while reset is low, unless a fault is commanded
  // A latch process runs at time zero, so the pin is never left unknown
  always_latch
  begin
    if (!resetn_i)
      pll_q <= ctl_pll_i;
  end
  assign pll_source_select_o = pll_q ^ flip_pll_i;
  assign oscillator_disable_o = pll_source_select_o ^ bad_osc_i;
endmodule : rscl_strap_drv

// ==== verif/tb_reset_strap_config_latch.sv ====
// Self-checking bench for the reset strap latch
`timescale 1ns/1ps
`include "rscl_cfg.svh"
module tb_reset_strap_config_latch;
  logic sys_clk_i = 1'h0, resetn_i = 1'h0, timer0_output_i = 1'h0, timer1_output_i = 1'h0;
  logic mem_clock_input_i = 1'h1, reg_req_i = 1'h0, reg_we_i = 1'h0, reg_ack_o;
  logic [31:0] reg_addr_i = 32'h0, reg_wdata_i = 32'h0, reg_rdata_o, peripheral_select_o, rd;
  logic byte_order_strap_i, host_port_enable_strap_i, host_width_strap_i;
  logic pll_source_select_i, oscillator_disable_i;
  logic [3:0] ext_addr_strap_bus_i;
  logic byte_order_mode_o, boot_reserved_o, mem_clk_en_o, mem_clk_reserved_o;
  logic host_port_en_o, audio2_en_o, gpio_hi_en_o, host_port_width_o, host_upper_en_o;
  logic pll_source_o, osc_mismatch_o, clk_pin_changed_o, ext_addr_oe_o;
  logic timer0_output_o, timer0_output_oe_o, timer1_output_o, timer1_output_oe_o;
  rscl_pkg::rscl_boot_type boot_mode_o;
  rscl_pkg::rscl_mclk_type mem_clock_select_o;
  logic drv = 1'h0, pll = 1'h1, bad_osc = 1'h0, flip = 1'h0;
  rscl_pkg::rscl_strap_type st = '0;
  int errors = 0, n_compared = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  rscl_strap_latch u_rscl_strap_latch (.*);
  rscl_strap_drv u_rscl_strap_drv (.resetn_i, .ctl_drive_i(drv), .ctl_straps_i(st),
    .ctl_pll_i(pll), .bad_osc_i(bad_osc), .flip_pll_i(flip), .timer0_output_i(timer0_output_o),
    .timer0_output_oe_i(timer0_output_oe_o), .timer1_output_i(timer1_output_o),
    .timer1_output_oe_i(timer1_output_oe_o), .ext_addr_oe_i(ext_addr_oe_o),
    .byte_order_strap_o(byte_order_strap_i), .ext_addr_strap_bus_o(ext_addr_strap_bus_i),
    .host_port_enable_strap_o(host_port_enable_strap_i),
    .host_width_strap_o(host_width_strap_i), .pll_source_select_o(pll_source_select_i),
    .oscillator_disable_o(oscillator_disable_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("Compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // One request, held for one cycle and released after the acknowledge is checked
  task automatic reg_op(input logic we, input logic [31:0] a, input logic [31:0] d);
    @(negedge sys_clk_i);
    reg_req_i = 1'h1;
    reg_we_i = we;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge sys_clk_i);
    check("ack", 32'(reg_ack_o), 32'h1);
    rd = reg_rdata_o;
    reg_req_i = 1'h0;
  endtask : reg_op
  task automatic go(input rscl_pkg::rscl_strap_type s, input logic p, input logic bo);
    @(negedge sys_clk_i);
    resetn_i = 1'h0;
    drv = 1'h1;
    st = s;
    pll = p;
    bad_osc = bo;
    flip = 1'h0;
    repeat (2) @(negedge sys_clk_i);
    check("oe_reset", 32'({timer0_output_oe_o, timer1_output_oe_o, ext_addr_oe_o}),
      32'h0);
    resetn_i = 1'h1;
    @(negedge sys_clk_i);
    check("oe_run", 32'({timer0_output_oe_o, timer1_output_oe_o, ext_addr_oe_o}),
      32'h7);
  endtask : go
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_decode(input logic [1:0] i);
    int n = 0;
    go(rscl_pkg::rscl_strap_type'({i[0], i, ~i, i[1], ~i[0]}), i[0], 1'b0);
    check("byte_order", 32'(byte_order_mode_o), 32'(st.byte_order));
    check("boot", 32'({boot_mode_o, boot_reserved_o}),
      32'({st.boot, st.boot == 2'h2}));
    check("mclk", 32'({mem_clock_select_o, mem_clk_reserved_o}),
      32'({st.mclk, st.mclk == 2'h3}));
    check("host", 32'({host_port_en_o, audio2_en_o, gpio_hi_en_o}),
      32'({~st.host_dis, st.host_dis, st.host_dis}));
    check("width", 32'({host_port_width_o, host_upper_en_o}),
      32'({st.width, st.width & ~st.host_dis}));
    check("pll_src", 32'(pll_source_o), 32'(pll));
    // Pin toggles each cycle, so mode 00 must mirror it rather than run free
    repeat (12)
    begin
      @(negedge sys_clk_i);
      n += int'(mem_clk_en_o);
      mem_clock_input_i = ~mem_clock_input_i;
    end
    check("mem_clk_en", 32'(n), (st.mclk == 2'h0) ? 32'h6 : (st.mclk == 2'h1) ? 32'h3 :
      (st.mclk == 2'h2) ? 32'h2 : 32'h0);
  endtask : test_decode
  // Pins move after reset; the latched set must not
  task automatic test_hold();
    @(negedge sys_clk_i);
    timer0_output_i = 1'h1;
    timer1_output_i = 1'h1;
    flip = 1'h1;
    repeat (3) @(negedge sys_clk_i);
    check("hold", 32'({byte_order_mode_o, host_port_en_o, pll_source_o, mem_clock_select_o}),
      32'({st.byte_order, ~st.host_dis, pll, st.mclk}));
    check("pin_changed", 32'(clk_pin_changed_o), 32'h1);
    check("timer_pads", 32'({timer0_output_o, timer1_output_o}), 32'h3);
  endtask : test_hold
  task automatic test_regs();
    reg_op(1'b0, `RSCL_PERIPH_SEL_ADDR, 32'h0);
    check("psel_reset", rd, `RSCL_PERIPH_SEL_RESET);
    reg_op(1'h1, `RSCL_PERIPH_SEL_ADDR, 32'ha5a5_5a5a);
    check("psel_out", peripheral_select_o, 32'ha5a5_5a5a);
    reg_op(1'b1, `RSCL_STATUS_ADDR, 32'hffff_ffff);
    reg_op(1'b0, `RSCL_PERIPH_SEL_ADDR, 32'h0);
    check("psel_read", rd, 32'ha5a5_5a5a);
    reg_op(1'b0, `RSCL_STATUS_ADDR, 32'h0);
    check("status", rd, {23'h0, 1'h1, 1'h0, st});
    reg_op(1'b0, 32'h01b3_f008, 32'h0);
    check("unmapped", rd, 32'h0);
  endtask : test_regs
  task automatic test_osc();
    go(st, 1'b0, 1'b1);
    check("osc_mismatch", 32'({osc_mismatch_o, pll_source_o, clk_pin_changed_o}),
      32'h4);
  endtask : test_osc
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(negedge sys_clk_i);
    for (int i = 0; i < 4; i++)
      test_decode(2'(i));
    test_hold();
    test_regs();
    test_osc();
    end_of_test();
  end
  initial
  begin
    #100000;
    errors++;
    end_of_test();
  end
endmodule : tb_reset_strap_config_latch
